// File: rtl/ebp_pkg.sv
// Constants, register map and state layout for the eight-bit port block.
// Assumes a single 25 MHz clock and a 32-bit APB register bus.
`default_nettype none

package ebp_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int unsigned PORT_W     = 8;
   localparam int unsigned APB_DATA_W = 32;
   localparam int unsigned REG_ADDR_W = 5;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [REG_ADDR_W-1:0] PIN_LEVEL_OFS     = 5'h00;
   localparam logic [REG_ADDR_W-1:0] OUTPUT_LATCH_OFS  = 5'h04;
   localparam logic [REG_ADDR_W-1:0] DIRECTION_OFS     = 5'h08;
   localparam logic [REG_ADDR_W-1:0] MEMORY_CTRL_OFS   = 5'h0C;
   localparam logic [REG_ADDR_W-1:0] SLAVE_PORT_CTRL_OFS = 5'h10;
   localparam logic [REG_ADDR_W-1:0] STATUS_OFS        = 5'h14;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned EXT_BUS_DISABLE_POS = 7;
   localparam int unsigned SLAVE_PORT_MODE_POS = 4;
   localparam int unsigned PSP_READ_POS        = 0;
   localparam int unsigned PSP_WRITE_POS       = 1;
   localparam int unsigned PSP_SELECT_POS      = 2;
   localparam int unsigned CCP_PIN_POS         = 7;
   localparam int unsigned STAT_BUS_ACTIVE_POS = 0;
   localparam int unsigned STAT_REMAP_POS      = 1;
   localparam int unsigned STAT_PSP_POS        = 2;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [PORT_W-1:0] DIRECTION_RESET   = 8'hFF;
   localparam logic [PORT_W-1:0] LATCH_RESET       = 8'h00;
   localparam logic              EXT_BUS_DIS_RESET = 1'b1;
   localparam logic              PSP_MODE_RESET    = 1'b0;
   localparam logic [2:0]        PSP_IDLE          = 3'h7;
   localparam logic [APB_DATA_W-1:0] DATA_ZERO     = 32'h0000_0000;

   // ****************************************************************
   // Whole state of the top module
   // ****************************************************************
   typedef struct packed {
      logic [PORT_W-1:0]     pin_sample;
      logic [PORT_W-1:0]     latch;
      logic [PORT_W-1:0]     direction;
      logic                  ext_bus_disable;
      logic                  slave_port_mode;
      logic                  remap_fuse;
      logic                  internal_mode;
      logic [APB_DATA_W-1:0] prdata;
      logic                  pslverr;
      logic                  ccp_capture;
      logic [2:0]            psp_ctl_n;
      logic [PORT_W-1:0]     bus_in;
   } ebp_state_s;

endpackage

`default_nettype wire

// File: rtl/ebp_pin_if.sv
// Carrier between the port's register logic and its pin multiplexer.
// Assumes both ends sit in the same clock domain; no clocking here.
`default_nettype none

interface ebp_pin_if;
   import ebp_pkg::*;

   logic [PORT_W-1:0] direction;
   logic [PORT_W-1:0] latch;
   logic              bus_active;
   logic [PORT_W-1:0] bus_out;
   logic [PORT_W-1:0] bus_oe;
   logic              remap_active;
   logic              ccp_out;
   logic [PORT_W-1:0] pin_out;
   logic [PORT_W-1:0] pin_oe;

   modport ctrl (
      output direction, latch, bus_active, bus_out, bus_oe, remap_active, ccp_out,
      input  pin_out, pin_oe
   );

   modport mux (
      input  direction, latch, bus_active, bus_out, bus_oe, remap_active, ccp_out,
      output pin_out, pin_oe
   );

endinterface

`default_nettype wire

// File: rtl/ebp_pin_mux.sv
// Per-pin output multiplexer of the eight-bit port.
// Assumes all inputs come from flip-flops or from the bus block's registers.
`default_nettype none

module ebp_pin_mux
   import ebp_pkg::*;
(
   ebp_pin_if.mux pins  // Control in, pin drive out
);

   // ****************************************************************
   // Priority: external bus, then timer channel, then latch
   // ****************************************************************
   always_comb
   begin
      pins.pin_out = pins.latch;
      pins.pin_oe  = ~pins.direction;
      if (pins.remap_active && !pins.direction[CCP_PIN_POS])
      begin
         pins.pin_out[CCP_PIN_POS] = pins.ccp_out;
      end
      if (pins.bus_active)
      begin
         // Direction bits play no part while the bus owns the pins
         pins.pin_out = pins.bus_out;
         pins.pin_oe  = pins.bus_oe;
      end
   end

endmodule

`default_nettype wire

// File: rtl/ebp_port.sv
// Eight-bit general-purpose port with bus, slave-port and timer overrides.
// Assumes an APB master on the same 25 MHz clock, a memory bus sequencer
// that supplies address/data drive, and a host on the parallel slave port.
`default_nettype none

module ebp_port
   import ebp_pkg::*;
#(
   parameter bit          LARGE_PACKAGE = 1'b1,  // Package has the memory bus
   parameter int unsigned APB_ADDR_W    = 12     // Width of paddr
)
(
   input  wire logic                    clock,          // 25 MHz system clock
   input  wire logic                    reset,          // Synchronous, active high
   // APB slave
   input  wire logic                    psel,           // Slave select
   input  wire logic                    penable,        // Access phase
   input  wire logic                    pwrite,         // Write when high
   input  wire logic [APB_ADDR_W-1:0]   paddr,          // Byte address
   input  wire logic [APB_DATA_W-1:0]   pwdata,         // Write data
   input  wire logic [3:0]              pstrb,          // Byte strobes
   output logic                         pready,         // Transfer done
   output logic      [APB_DATA_W-1:0]   prdata,         // Read data
   output logic                         pslverr,        // Unmapped address
   // Pins
   input  wire logic [PORT_W-1:0]       pin_in,         // Pin levels
   output logic      [PORT_W-1:0]       pin_out,        // Pin drive value
   output logic      [PORT_W-1:0]       pin_oe,         // High while driving
   // Configuration
   input  wire logic                    timer_channel_remap_fuse, // Fuse bit
   input  wire logic                    internal_program_mode,    // Mode strap
   // External memory bus sequencer
   input  wire logic [PORT_W-1:0]       bus_high_byte_out, // Address/data out
   input  wire logic [PORT_W-1:0]       bus_high_byte_oe,  // Drive enables
   output logic      [PORT_W-1:0]       bus_high_byte_in,  // Sampled data in
   output logic                         ext_bus_active,    // Bus owns pins
   // Capture/compare/PWM channel
   input  wire logic                    capture_compare_pwm_out,   // Compare/PWM
   output logic                         capture_compare_pwm_in,    // Capture in
   output logic                         capture_compare_pwm_remap, // On bit 7
   // Parallel slave port control
   output logic                         slave_port_mode,    // Mode bit
   output logic                         psp_read_n,         // Read strobe
   output logic                         psp_write_n,        // Write strobe
   output logic                         psp_select_n        // Chip select
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (APB_ADDR_W < REG_ADDR_W)
   begin : g_addr_check
      $error("ebp_port: APB_ADDR_W too narrow for the register map");
   end

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Word-aligned hit on one register offset
   function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] addr,
                                    input logic [REG_ADDR_W-1:0] ofs);
      logic upper_zero;
      upper_zero = (addr >> REG_ADDR_W) == '0;
      return upper_zero && (addr[REG_ADDR_W-1:0] == ofs);
   endfunction

   // Place a port byte in the low lane of a bus word
   function automatic logic [APB_DATA_W-1:0] low_byte(input logic [PORT_W-1:0] b);
      return {{(APB_DATA_W-PORT_W){1'b0}}, b};
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   ebp_state_s s;
   ebp_state_s next_s;

   ebp_pin_if pins ();

   logic bus_active;
   logic remap_active;
   logic setup_phase;
   logic write_taken;
   logic low_lane;
   logic [APB_DATA_W-1:0] read_word;
   logic read_mapped;

   // Only the larger package can hand the pins to the memory bus
   assign bus_active   = LARGE_PACKAGE && !s.ext_bus_disable;
   assign remap_active = s.internal_mode && !s.remap_fuse;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   // No wait cycles: read data is registered in setup, answered in access
   assign setup_phase = psel && !penable;
   assign write_taken = psel && penable && pwrite;
   assign low_lane    = pstrb[0];

   always_comb
   begin
      read_word   = DATA_ZERO;
      read_mapped = 1'b1;
      if (reg_hit(paddr, PIN_LEVEL_OFS))
      begin
         read_word = low_byte(s.pin_sample);
      end
      else if (reg_hit(paddr, OUTPUT_LATCH_OFS))
      begin
         read_word = low_byte(s.latch);
      end
      else if (reg_hit(paddr, DIRECTION_OFS))
      begin
         read_word = low_byte(s.direction);
      end
      else if (reg_hit(paddr, MEMORY_CTRL_OFS))
      begin
         read_word[EXT_BUS_DISABLE_POS] = s.ext_bus_disable;
      end
      else if (reg_hit(paddr, SLAVE_PORT_CTRL_OFS))
      begin
         read_word[SLAVE_PORT_MODE_POS] = s.slave_port_mode;
      end
      else if (reg_hit(paddr, STATUS_OFS))
      begin
         read_word[STAT_BUS_ACTIVE_POS] = bus_active;
         read_word[STAT_REMAP_POS]      = remap_active;
         read_word[STAT_PSP_POS]        = s.slave_port_mode && !bus_active;
      end
      else
      begin
         read_mapped = 1'b0;
      end
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      next_s = s;

      // Pins are sampled every cycle; the bus sequencer gets its own sample only while the bus is active
      next_s.pin_sample = pin_in;

      if (setup_phase)
      begin
         next_s.prdata  = pwrite ? DATA_ZERO : read_word;
         next_s.pslverr = !read_mapped;
      end

      if (write_taken && low_lane)
      begin
         if (reg_hit(paddr, PIN_LEVEL_OFS))
         begin
            // Writing the pin-level register lands in the latch
            next_s.latch = pwdata[PORT_W-1:0];
         end
         else if (reg_hit(paddr, OUTPUT_LATCH_OFS))
         begin
            next_s.latch = pwdata[PORT_W-1:0];
         end
         else if (reg_hit(paddr, DIRECTION_OFS))
         begin
            next_s.direction = pwdata[PORT_W-1:0];
         end
         else if (reg_hit(paddr, MEMORY_CTRL_OFS))
         begin
            next_s.ext_bus_disable = pwdata[EXT_BUS_DISABLE_POS];
         end
         else if (reg_hit(paddr, SLAVE_PORT_CTRL_OFS))
         begin
            // Direction bits are left alone; software sets them itself
            next_s.slave_port_mode = pwdata[SLAVE_PORT_MODE_POS];
         end
      end

      // Inbound data for the memory bus, whatever the direction bits say
      if (bus_active)
      begin
         next_s.bus_in = pin_in;
      end

      // Capture input only when the remapped pin is an input
      next_s.ccp_capture = remap_active && s.direction[CCP_PIN_POS] && !bus_active
                           ? pin_in[CCP_PIN_POS]
                           : 1'b0;

      // Slave port strobes; the memory bus wins over them
      if (s.slave_port_mode && !bus_active)
      begin
         next_s.psp_ctl_n = {pin_in[PSP_SELECT_POS],
                             pin_in[PSP_WRITE_POS],
                             pin_in[PSP_READ_POS]};
      end
      else
      begin
         next_s.psp_ctl_n = PSP_IDLE;
      end

      if (reset)
      begin
         next_s.pin_sample      = pin_in;
         next_s.latch           = LATCH_RESET;
         next_s.direction       = DIRECTION_RESET;
         next_s.ext_bus_disable = EXT_BUS_DIS_RESET;
         next_s.slave_port_mode = PSP_MODE_RESET;
         // Straps are followed while reset is held and frozen at release
         next_s.remap_fuse      = timer_channel_remap_fuse;
         next_s.internal_mode   = internal_program_mode;
         next_s.prdata          = DATA_ZERO;
         next_s.pslverr         = 1'b0;
         next_s.ccp_capture     = 1'b0;
         next_s.psp_ctl_n       = PSP_IDLE;
         next_s.bus_in          = LATCH_RESET;
      end
   end

   always_ff @(posedge clock)
   begin
      s <= next_s;
   end

   // ****************************************************************
   // Pin multiplexer
   // ****************************************************************
   assign pins.direction    = s.direction;
   assign pins.latch        = s.latch;
   assign pins.bus_active   = bus_active;
   assign pins.bus_out      = bus_high_byte_out;
   assign pins.bus_oe       = bus_high_byte_oe;
   assign pins.remap_active = remap_active;
   assign pins.ccp_out      = capture_compare_pwm_out;

   ebp_pin_mux u_pin_mux (
      .pins (pins.mux)
   );

   // Reset state drives the pins as inputs, so no pin moves at power-up
   assign pin_out = pins.pin_out;
   assign pin_oe  = pins.pin_oe;

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign pready                    = psel && penable;
   assign prdata                    = s.prdata;
   assign pslverr                   = psel && penable && s.pslverr;
   assign bus_high_byte_in          = s.bus_in;
   assign ext_bus_active            = bus_active;
   assign capture_compare_pwm_in    = s.ccp_capture;
   assign capture_compare_pwm_remap = remap_active;
   assign slave_port_mode           = s.slave_port_mode;
   assign psp_read_n                = s.psp_ctl_n[0];
   assign psp_write_n               = s.psp_ctl_n[1];
   assign psp_select_n              = s.psp_ctl_n[2];

endmodule

`default_nettype wire

// File: test/ebp_pin_model.sv
// Far-side model of the eight port pins: external drivers and the host.
// Assumes the bench supplies the far-side levels and which bits it drives.
`default_nettype none

module ebp_pin_model
   import ebp_pkg::*;
(
   input  wire logic              clock,    // System clock
   input  wire logic [PORT_W-1:0] pin_out,  // Port drive value
   input  wire logic [PORT_W-1:0] pin_oe,   // Port drive enables
   input  wire logic [PORT_W-1:0] ext_val,  // Far-side level
   input  wire logic [PORT_W-1:0] ext_en,   // Far side drives the bit
   output logic      [PORT_W-1:0] pin_in    // Resolved wire level
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [PORT_W-1:0] last;

   // Undriven bits flip, so a stale level never passes for a real one
   always_comb
   begin
      pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
             | (~pin_oe & ~ext_en & ~last);
   end

   always_ff @(posedge clock)
   begin
      last <= pin_in;
   end
endmodule

`default_nettype wire

// File: test/ebp_port_asserts.sv
// Checker of the eight-bit port, watching the top module's ports only.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none

module ebp_port_asserts
   import ebp_pkg::*;
#(
   parameter int unsigned APB_ADDR_W = 12  // Width of paddr
)
(
   input wire logic              clock,                     // System clock
   input wire logic              reset,                     // Active high
   input wire logic              psel,                      // Select
   input wire logic              penable,                   // Access phase
   input wire logic              pready,                    // Done
   input wire logic              pslverr,                   // Error
   input wire logic [PORT_W-1:0] pin_in,                    // Pin levels
   input wire logic [PORT_W-1:0] pin_out,                   // Drive value
   input wire logic [PORT_W-1:0] pin_oe,                    // Drive enables
   input wire logic              timer_channel_remap_fuse,  // Fuse
   input wire logic              internal_program_mode,     // Strap
   input wire logic [PORT_W-1:0] bus_high_byte_out,         // Bus drive
   input wire logic [PORT_W-1:0] bus_high_byte_oe,          // Bus enables
   input wire logic [PORT_W-1:0] bus_high_byte_in,          // Bus sample
   input wire logic              ext_bus_active,            // Bus owns pins
   input wire logic              capture_compare_pwm_out,   // Compare out
   input wire logic              capture_compare_pwm_in,    // Capture in
   input wire logic              capture_compare_pwm_remap, // On bit 7
   input wire logic              slave_port_mode,           // Mode bit
   input wire logic              psp_read_n,                // Read strobe
   input wire logic              psp_write_n,               // Write strobe
   input wire logic              psp_select_n               // Chip select
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   chk_pready_access: assert property (pready == (psel && penable))
      else $error("pready outside access phase");
   chk_slverr_window: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   chk_reset_inputs: assert property ($fell(reset) |-> !ext_bus_active && pin_oe == 8'h00)
      else $error("pins not inputs after reset");
   chk_strap_latch: assert property ($fell(reset) |-> capture_compare_pwm_remap ==
      ($past(internal_program_mode) && !$past(timer_channel_remap_fuse)))
      else $error("remap not taken from straps");
   chk_strap_frozen: assert property (1'b1 |=> $stable(capture_compare_pwm_remap))
      else $error("remap changed after reset");
   chk_bus_drive: assert property (ext_bus_active |-> pin_oe == bus_high_byte_oe
      && pin_out == bus_high_byte_out)
      else $error("bus does not own pins");
   chk_bus_sample: assert property (ext_bus_active |=> bus_high_byte_in == $past(pin_in))
      else $error("bus data in not sampled");
   chk_ccp_override: assert property (capture_compare_pwm_remap && !ext_bus_active
      && pin_oe[7] |-> pin_out[7] == capture_compare_pwm_out)
      else $error("compare output not on bit 7");
   chk_ccp_capture: assert property (capture_compare_pwm_remap && !ext_bus_active
      && !pin_oe[7] |=> capture_compare_pwm_in == $past(pin_in[7]))
      else $error("capture input not from bit 7");
   chk_psp_sample: assert property (slave_port_mode && !ext_bus_active |=>
      {psp_select_n, psp_write_n, psp_read_n} == $past(pin_in[2:0]))
      else $error("slave strobes not sampled");
   chk_psp_idle: assert property (ext_bus_active |=>
      {psp_select_n, psp_write_n, psp_read_n} == 3'h7)
      else $error("slave strobes active under bus");
endmodule

bind ebp_port ebp_port_asserts #(.APB_ADDR_W(APB_ADDR_W)) u_chk (
   .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .timer_channel_remap_fuse(timer_channel_remap_fuse),
   .internal_program_mode(internal_program_mode), .bus_high_byte_out(bus_high_byte_out),
   .bus_high_byte_oe(bus_high_byte_oe), .bus_high_byte_in(bus_high_byte_in),
   .ext_bus_active(ext_bus_active), .capture_compare_pwm_out(capture_compare_pwm_out),
   .capture_compare_pwm_in(capture_compare_pwm_in),
   .capture_compare_pwm_remap(capture_compare_pwm_remap), .slave_port_mode(slave_port_mode),
   .psp_read_n(psp_read_n), .psp_write_n(psp_write_n), .psp_select_n(psp_select_n));

`default_nettype wire

// File: test/ebp_port_tb.sv
// Self-checking bench of the eight-bit port, driving APB and the pins.
// Assumes the pin model and the bound checker are compiled beforehand.
`default_nettype none

module ebp_port_tb;
   import ebp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int AW = 12;
   logic clock, reset, psel, penable, pwrite, pready, pslverr, err;
   logic fuse, imode, ccp_out, ccp_in, remap, ext_act, spm, rd_n, wr_n, cs_n;
   logic [AW-1:0] paddr;
   logic [31:0]   pwdata, prdata, rd;
   logic [3:0]    pstrb;
   logic [7:0]    pin_in, pin_out, pin_oe, bus_out, bus_oe, bus_in, ext_val;
   int            n_mismatch, checks_done, cycles;

   ebp_port #(.APB_ADDR_W(AW)) dut (.clock(clock), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .timer_channel_remap_fuse(fuse),
      .internal_program_mode(imode), .bus_high_byte_out(bus_out), .bus_high_byte_oe(bus_oe),
      .bus_high_byte_in(bus_in), .ext_bus_active(ext_act), .capture_compare_pwm_out(ccp_out),
      .capture_compare_pwm_in(ccp_in), .capture_compare_pwm_remap(remap),
      .slave_port_mode(spm), .psp_read_n(rd_n), .psp_write_n(wr_n), .psp_select_n(cs_n));

   ebp_pin_model model (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
      .ext_val(ext_val), .ext_en(8'hFF), .pin_in(pin_in));

   // ****************************************************************
   // Clock, timeout and tasks
   // ****************************************************************
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic apb(input logic wr, input logic [REG_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= AW'(a);
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   task automatic print_verdict();
      $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial
   begin
      {reset, fuse, imode, ccp_out, psel, penable, pwrite} = 7'b1010000;
      {paddr, pwdata, pstrb, bus_out, bus_oe, ext_val} = {12'h000, 32'h0, 4'hF, 16'h0, 8'h5A};
      {n_mismatch, checks_done, cycles} = {32'd0, 32'd0, 32'd0};
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      check(32'(pin_oe), 32'h00);
      apb(1'b0, DIRECTION_OFS, DATA_ZERO);
      check(rd, 32'hFF);
      apb(1'b0, MEMORY_CTRL_OFS, DATA_ZERO);
      check(rd, 32'h80);
      apb(1'b1, OUTPUT_LATCH_OFS, 32'hA5);
      apb(1'b1, DIRECTION_OFS, 32'h0F);
      @(negedge clock);
      check(32'(pin_oe), 32'hF0);
      check(32'(pin_out[7:4]), 32'h2);
      @(posedge clock);
      ccp_out <= 1'b1;
      @(negedge clock);
      check(32'(pin_out[7]), 32'h1);
      apb(1'b0, PIN_LEVEL_OFS, DATA_ZERO);
      check(rd, 32'hAA);
      apb(1'b1, DIRECTION_OFS, 32'hFF);
      apb(1'b0, OUTPUT_LATCH_OFS, DATA_ZERO);
      check(rd, 32'hA5);
      apb(1'b0, PIN_LEVEL_OFS, DATA_ZERO);
      check(rd, 32'h5A);
      apb(1'b1, PIN_LEVEL_OFS, 32'h3C);
      apb(1'b0, OUTPUT_LATCH_OFS, DATA_ZERO);
      check(rd, 32'h3C);
      ext_val <= 8'hDA;
      repeat (2) @(posedge clock);
      @(negedge clock);
      check(32'(ccp_in), 32'h1);
      apb(1'b0, 5'h18, DATA_ZERO);
      check({rd[30:0], err}, 32'h1);
      // Strobe pins were left as inputs by the direction write above
      apb(1'b1, SLAVE_PORT_CTRL_OFS, 32'h10);
      ext_val <= 8'hD9;
      repeat (2) @(posedge clock);
      @(negedge clock);
      check(32'({spm, cs_n, wr_n, rd_n}), 32'h9);
      apb(1'b0, STATUS_OFS, DATA_ZERO);
      check(rd, 32'h6);
      bus_out <= 8'h3C;
      bus_oe <= 8'h0F;
      apb(1'b1, MEMORY_CTRL_OFS, DATA_ZERO);
      @(negedge clock);
      check(32'({ext_act, pin_oe, pin_out[3:0]}), 32'h10FC);
      repeat (2) @(posedge clock);
      @(negedge clock);
      check(32'({bus_in, cs_n, wr_n, rd_n}), 32'h6E7);
      apb(1'b0, STATUS_OFS, DATA_ZERO);
      check(rd, 32'h3);
      apb(1'b1, MEMORY_CTRL_OFS, 32'h80);
      @(negedge clock);
      check(32'({ext_act, pin_oe}), 32'h000);
      print_verdict();
   end
endmodule

`default_nettype wire
